//--- logic/pss_pkg.sv
// constants and types for the set-point and status logic
package pss_pkg;
	// object dictionary indices
	localparam logic [15:0] OD_FAULT_CODE    = 16'h603f;
	localparam logic [15:0] OD_CMD_WORD      = 16'h6040;
	localparam logic [15:0] OD_STATE_WORD    = 16'h6041;
	localparam logic [15:0] OD_MODE_SELECT   = 16'h6060;
	localparam logic [15:0] OD_MODE_SHOWN    = 16'h6061;
	localparam logic [15:0] OD_ENC_POS       = 16'h6063;
	localparam logic [15:0] OD_ACT_POS       = 16'h6064;
	localparam logic [15:0] OD_FOLLOW_WIN    = 16'h6065;
	localparam logic [15:0] OD_POS_WIN       = 16'h6067;
	localparam logic [15:0] OD_POS_WIN_TIME  = 16'h6068;
	localparam logic [15:0] OD_ACT_SPEED     = 16'h606c;
	localparam logic [15:0] OD_VEL_WIN       = 16'h606d;
	localparam logic [15:0] OD_VEL_WIN_TIME  = 16'h606e;
	localparam logic [15:0] OD_ACT_TORQUE    = 16'h6077;
	localparam logic [15:0] OD_TARGET_POS    = 16'h607a;
	localparam logic [15:0] OD_SPEED_CEIL    = 16'h607f;
	localparam logic [15:0] OD_PROF_VEL      = 16'h6081;
	localparam logic [15:0] OD_RAMP_UP       = 16'h6083;
	localparam logic [15:0] OD_RAMP_DOWN     = 16'h6084;
	localparam logic [15:0] OD_FWD_TQ_CAP    = 16'h60e0;
	localparam logic [15:0] OD_REV_TQ_CAP    = 16'h60e1;
	localparam logic [15:0] OD_POS_DEV       = 16'h60f4;
	localparam logic [15:0] OD_SPEED_SETPT   = 16'h60ff;
	// command word bits
	localparam int CMD_NEW_SETPT = 4;
	localparam int CMD_IMMEDIATE = 5;
	localparam int CMD_RELATIVE  = 6;
	// state word bits
	localparam int ST_REACHED    = 10;
	localparam int ST_SETPT_ACK  = 12;
	localparam int ST_FOLLOW_ERR = 13;
	// reset values
	localparam logic [15:0] RAMP_RST   = 16'h0064;
	localparam logic [15:0] TQ_CAP_RST = 16'h0064;
	// operating modes
	localparam logic [15:0] MODE_PROFILE_POS = 16'h0001;
	localparam logic [15:0] MODE_PROFILE_VEL = 16'h0003;
	// following_error_alarm_code, value arbitrary
	localparam logic [15:0] FOLLOW_ALARM = 16'h0009;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS         = 1000000;
	localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		PSS_IDLE   = 2'b00,
		PSS_MOVE   = 2'b01,
		PSS_SETTLE = 2'b11
	} pss_move_t;
endpackage : pss_pkg

//--- logic/pss_setpoint_status.sv
// set-point handshake, reached windows and following error of a servo drive
`timescale 1ns/100ps
module pss_setpoint_status
	import pss_pkg::*;
#(
	parameter int CYCLES_PER_MS = CYC_PER_MS
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        od_wr,
	input  wire logic        od_rd,
	input  wire logic [15:0] od_index,
	input  wire logic [31:0] od_wdata,
	output logic      [31:0] od_rdata,
	output logic             od_ack,
	input  wire logic [31:0] pos_command,
	input  wire logic [31:0] encoder_position,
	input  wire logic [31:0] actual_position,
	input  wire logic [31:0] actual_speed,
	input  wire logic [15:0] actual_torque,
	input  wire logic        move_done,
	input  wire logic        servo_on_pin,
	output logic             run_enable,
	output logic             new_move,
	output logic      [31:0] move_target,
	output logic      [15:0] move_speed,
	output logic      [15:0] move_ramp_up,
	output logic      [15:0] move_ramp_down,
	output logic             pos_reached_do,
	output logic             speed_reached_do,
	output logic      [15:0] keypad_alarm,
	output logic      [15:0] drive_state_word
);

	////////////////////////////////////////////////////////////////////
	// object dictionary storage
	logic [15:0] cmd_word_r;
	logic [15:0] mode_r;
	logic [15:0] follow_win_r;
	logic [31:0] pos_win_r;
	logic [15:0] pos_time_r;
	logic [15:0] vel_win_r;
	logic [15:0] vel_time_r;
	logic [31:0] target_r;
	logic [31:0] speed_ceil_r;
	logic [15:0] prof_vel_r;
	logic [15:0] ramp_up_r;
	logic [15:0] ramp_down_r;
	logic [15:0] fwd_cap_r;
	logic [15:0] rev_cap_r;
	logic [31:0] speed_setpt_r;
	logic [15:0] fault_r;
	logic [31:0] dev_r;

	wire cmd_we = od_wr && (od_index == OD_CMD_WORD);
	// read-only and unmapped indices fall through the default

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cmd_word_r    <= 16'h0000;
			mode_r        <= 16'h0000;
			follow_win_r  <= 16'h0000;
			pos_win_r     <= 32'h00000000;
			pos_time_r    <= 16'h0000;
			vel_win_r     <= 16'h0000;
			vel_time_r    <= 16'h0000;
			target_r      <= 32'h00000000;
			speed_ceil_r  <= 32'h00000000;
			prof_vel_r    <= 16'h0000;
			ramp_up_r     <= RAMP_RST;
			ramp_down_r   <= RAMP_RST;
			fwd_cap_r     <= TQ_CAP_RST;
			rev_cap_r     <= TQ_CAP_RST;
			speed_setpt_r <= 32'h00000000;
		end else if (od_wr) begin
			case (od_index)
				OD_CMD_WORD:     cmd_word_r    <= od_wdata[15:0];
				OD_MODE_SELECT:  mode_r        <= od_wdata[15:0];
				OD_FOLLOW_WIN:   follow_win_r  <= od_wdata[15:0];
				OD_POS_WIN:      pos_win_r     <= od_wdata;
				OD_POS_WIN_TIME: pos_time_r    <= od_wdata[15:0];
				OD_VEL_WIN:      vel_win_r     <= od_wdata[15:0];
				OD_VEL_WIN_TIME: vel_time_r    <= od_wdata[15:0];
				OD_TARGET_POS:   target_r      <= od_wdata;
				OD_SPEED_CEIL:   speed_ceil_r  <= od_wdata;
				OD_PROF_VEL:     prof_vel_r    <= od_wdata[15:0];
				OD_RAMP_UP:      ramp_up_r     <= od_wdata[15:0];
				OD_RAMP_DOWN:    ramp_down_r   <= od_wdata[15:0];
				OD_FWD_TQ_CAP:   fwd_cap_r     <= od_wdata[15:0];
				OD_REV_TQ_CAP:   rev_cap_r     <= od_wdata[15:0];
				OD_SPEED_SETPT:  speed_setpt_r <= od_wdata;
				default:         ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// servo-on pin synchroniser
	logic son_meta_r;
	logic son_r;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			son_meta_r <= 1'b0;
			son_r      <= 1'b0;
		end else begin
			son_meta_r <= servo_on_pin;
			son_r      <= son_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// command decode
	wire run_ok   = (cmd_word_r[3:0] == 4'hf);
	wire is_pp    = (mode_r == MODE_PROFILE_POS);
	wire is_pv    = (mode_r == MODE_PROFILE_VEL);
	// mode bits travel with the word that raises bit 4
	wire immed    = od_wdata[CMD_IMMEDIATE];
	wire relative = od_wdata[CMD_RELATIVE];
	wire b4_new   = cmd_we && od_wdata[CMD_NEW_SETPT];
	wire b4_rise  = b4_new && !cmd_word_r[CMD_NEW_SETPT];
	wire b4_fall  = cmd_we && !od_wdata[CMD_NEW_SETPT]
		&& cmd_word_r[CMD_NEW_SETPT];

	////////////////////////////////////////////////////////////////////
	// deviation and window tests
	logic [31:0] dev_abs;
	logic [31:0] spd_err;
	logic [31:0] spd_abs;
	logic        pos_in_win;
	logic        vel_in_win;
	logic        follow_err;

	assign dev_abs    = dev_r[31] ? 32'(-dev_r) : dev_r;
	assign spd_err    = 32'(speed_setpt_r - actual_speed);
	assign spd_abs    = spd_err[31] ? 32'(-spd_err) : spd_err;
	assign pos_in_win = dev_abs <= pos_win_r;
	assign vel_in_win = spd_abs <= {16'h0000, vel_win_r};
	assign follow_err = is_pp && (dev_abs > {16'h0000, follow_win_r});

	always_ff @(posedge sys_clk) begin
		if (rst)
			dev_r <= 32'h00000000;
		else
			dev_r <= 32'(pos_command - actual_position);
	end

	////////////////////////////////////////////////////////////////////
	// dwell timers: channel 0 position, channel 1 velocity
	logic [1:0]  win_ok;
	logic [1:0]  dwell_met;
	logic [15:0] win_time [2];

	assign win_ok[0]   = is_pp && pos_in_win;
	assign win_ok[1]   = is_pv && vel_in_win && son_r;
	assign win_time[0] = pos_time_r;
	assign win_time[1] = vel_time_r;

	// one tick per ms, the ms count saturates
	for (genvar g = 0; g < 2; g++) begin : g_dwell
		logic [31:0] pre_r;
		logic [15:0] ms_r;
		wire         tick = (pre_r == 32'(CYCLES_PER_MS - 1));

		always_ff @(posedge sys_clk) begin
			if (rst || !win_ok[g]) begin
				pre_r <= 32'h00000000;
				ms_r  <= 16'h0000;
			end else if (tick) begin
				pre_r <= 32'h00000000;
				if (ms_r != 16'hffff)
					ms_r <= ms_r + 16'h0001;
			end else begin
				pre_r <= pre_r + 32'h00000001;
			end
		end
		assign dwell_met[g] = win_ok[g] && (ms_r >= win_time[g]);
	end

	////////////////////////////////////////////////////////////////////
	// set-point handshake
	pss_move_t   mv_r;
	pss_move_t   mv_nxt;
	logic [31:0] goal_r;
	logic        ack_r;
	logic        accept;
	logic        busy;

	assign busy   = (mv_r != PSS_IDLE);
	// deferred mode refuses anything before arrival
	assign accept = b4_rise && run_ok && is_pp
		&& (immed || !busy);

	always_comb begin
		mv_nxt = mv_r;
		case (mv_r)
			PSS_IDLE:   if (accept) mv_nxt = PSS_MOVE;
			PSS_MOVE:   if (move_done) mv_nxt = PSS_SETTLE;
			PSS_SETTLE: if (accept) mv_nxt = PSS_MOVE;
				else if (dwell_met[0]) mv_nxt = PSS_IDLE;
			default:    mv_nxt = PSS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst || !run_ok)
			mv_r <= PSS_IDLE;
		else
			mv_r <= mv_nxt;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			goal_r         <= 32'h00000000;
			move_speed     <= 16'h0000;
			move_ramp_up   <= RAMP_RST;
			move_ramp_down <= RAMP_RST;
		end else if (accept) begin
			// relative adds onto the unfinished goal
			goal_r         <= relative ? 32'(goal_r + target_r)
				: target_r;
			move_speed     <= prof_vel_r;
			move_ramp_up   <= ramp_up_r;
			move_ramp_down <= ramp_down_r;
		end
	end

	// set on accept takes priority over a clear
	always_ff @(posedge sys_clk) begin
		if (rst)
			ack_r <= 1'b0;
		else if (accept)
			ack_r <= 1'b1;
		else if (b4_fall)
			ack_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// outputs and status word
	// state word lags the internal decision by one cycle
	logic [15:0] state_nxt;

	always_comb begin
		state_nxt = 16'h0000;
		state_nxt[ST_REACHED] = is_pp ? (dwell_met[0] && !busy)
			: dwell_met[1];
		state_nxt[ST_SETPT_ACK] = is_pv ? (run_ok && son_r)
			: ack_r;
		state_nxt[ST_FOLLOW_ERR] = follow_err;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			run_enable       <= 1'b0;
			new_move         <= 1'b0;
			move_target      <= 32'h00000000;
			pos_reached_do   <= 1'b0;
			speed_reached_do <= 1'b0;
			keypad_alarm     <= 16'h0000;
			fault_r          <= 16'h0000;
			drive_state_word <= 16'h0000;
		end else begin
			run_enable       <= run_ok;
			new_move         <= accept;
			move_target      <= goal_r;
			pos_reached_do   <= is_pp && dwell_met[0];
			speed_reached_do <= dwell_met[1];
			keypad_alarm     <= follow_err ? FOLLOW_ALARM
				: 16'h0000;
			fault_r          <= follow_err ? FOLLOW_ALARM
				: 16'h0000;
			drive_state_word <= state_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// object dictionary read port
	// unmapped indices read zero and are still acknowledged
	logic [31:0] rd_mux;

	always_comb begin
		case (od_index)
			OD_FAULT_CODE:   rd_mux = {16'h0000, fault_r};
			OD_CMD_WORD:     rd_mux = {16'h0000, cmd_word_r};
			OD_STATE_WORD:   rd_mux = {16'h0000, drive_state_word};
			OD_MODE_SELECT:  rd_mux = {16'h0000, mode_r};
			OD_MODE_SHOWN:   rd_mux = {16'h0000, mode_r};
			OD_ENC_POS:      rd_mux = encoder_position;
			OD_ACT_POS:      rd_mux = actual_position;
			OD_FOLLOW_WIN:   rd_mux = {16'h0000, follow_win_r};
			OD_POS_WIN:      rd_mux = pos_win_r;
			OD_POS_WIN_TIME: rd_mux = {16'h0000, pos_time_r};
			OD_ACT_SPEED:    rd_mux = actual_speed;
			OD_VEL_WIN:      rd_mux = {16'h0000, vel_win_r};
			OD_VEL_WIN_TIME: rd_mux = {16'h0000, vel_time_r};
			OD_ACT_TORQUE:   rd_mux = {16'h0000, actual_torque};
			OD_TARGET_POS:   rd_mux = target_r;
			OD_SPEED_CEIL:   rd_mux = speed_ceil_r;
			OD_PROF_VEL:     rd_mux = {16'h0000, prof_vel_r};
			OD_RAMP_UP:      rd_mux = {16'h0000, ramp_up_r};
			OD_RAMP_DOWN:    rd_mux = {16'h0000, ramp_down_r};
			OD_FWD_TQ_CAP:   rd_mux = {16'h0000, fwd_cap_r};
			OD_REV_TQ_CAP:   rd_mux = {16'h0000, rev_cap_r};
			OD_POS_DEV:      rd_mux = dev_r;
			OD_SPEED_SETPT:  rd_mux = speed_setpt_r;
			default:         rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			od_rdata <= 32'h00000000;
			od_ack   <= 1'b0;
		end else begin
			od_rdata <= od_rd ? rd_mux : 32'h00000000;
			od_ack   <= od_rd || od_wr;
		end
	end

endmodule : pss_setpoint_status

//--- dv/pss_setpoint_status_sva.sv
// port assertions for the set-point and status logic
`timescale 1ns/100ps
module pss_setpoint_status_sva
	import pss_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        od_wr,
	input wire logic        od_rd,
	input wire logic [15:0] od_index,
	input wire logic [31:0] od_rdata,
	input wire logic        od_ack,
	input wire logic        servo_on_pin,
	input wire logic        run_enable,
	input wire logic        new_move,
	input wire logic [31:0] move_target,
	input wire logic        speed_reached_do,
	input wire logic [15:0] keypad_alarm,
	input wire logic [15:0] drive_state_word
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	ack_after_acc_a:
		assert property ((od_wr || od_rd) |=> od_ack)
		else $error("access not acknowledged");
	rdata_idle_a:
		assert property (!od_rd |=> od_rdata == 32'h0)
		else $error("read data without read");
	move_pulse_a:
		assert property (new_move |=> !new_move)
		else $error("accept pulse too long");
	ack_follows_a:
		assert property (new_move |=> drive_state_word[ST_SETPT_ACK])
		else $error("acknowledge missing after accept");
	ack_clear_a:
		assert property (disable iff (rst || !servo_on_pin)
			$fell(drive_state_word[ST_SETPT_ACK]) |->
			$past(od_wr && od_index == OD_CMD_WORD, 2))
		else $error("acknowledge dropped without command write");
	run_gate_a:
		assert property (new_move |-> run_enable)
		else $error("accept while not running");
	servo_gate_a:
		assert property (!servo_on_pin [*5] |-> !speed_reached_do)
		else $error("speed reached with servo off");
	alarm_show_a:
		assert property ($rose(drive_state_word[ST_FOLLOW_ERR]) |->
			##[0:1] keypad_alarm == FOLLOW_ALARM)
		else $error("alarm code missing");
	alarm_code_a:
		assert property (keypad_alarm == 16'h0 ||
			keypad_alarm == FOLLOW_ALARM)
		else $error("bad alarm code");
	target_hold_a:
		assert property (!new_move |=> $stable(move_target))
		else $error("target changed without accept");
	cover property (new_move);
	cover property ($fell(drive_state_word[ST_SETPT_ACK]));
	cover property ($rose(speed_reached_do));
	cover property ($rose(drive_state_word[ST_FOLLOW_ERR]));
endmodule : pss_setpoint_status_sva

//--- dv/pss_host.sv
// host side master of the object port
`timescale 1ns/100ps
module pss_host (
	input  wire logic        sys_clk,
	output logic             od_wr,
	output logic             od_rd,
	output logic      [15:0] od_index,
	output logic      [31:0] od_wdata,
	input  wire logic [31:0] od_rdata,
	input  wire logic        od_ack
);
	initial begin
		od_wr = 1'b0;
		od_rd = 1'b0;
		od_index = 16'h0;
		od_wdata = 32'h0;
	end
	// one strobe cycle, answer taken one cycle later
	task automatic acc(input logic w, input logic [15:0] i,
		input logic [31:0] d, output logic [31:0] q, output logic a);
		@(posedge sys_clk);
		#1;
		od_wr = w;
		od_rd = !w;
		od_index = i;
		od_wdata = d;
		@(posedge sys_clk);
		#1;
		a = od_ack;
		q = od_rdata;
		od_wr = 1'b0;
		od_rd = 1'b0;
		// released data no longer shows the last value
		od_wdata = ~d;
	endtask : acc
endmodule : pss_host

//--- dv/pss_setpoint_status_tb.sv
// self-checking bench for the set-point and status logic
`timescale 1ns/100ps
module pss_setpoint_status_tb;
	import pss_pkg::*;
	logic        sys_clk, rst, od_wr, od_rd, od_ack, move_done;
	logic        servo_on_pin, run_enable, new_move;
	logic        pos_reached_do, speed_reached_do, rel;
	logic [15:0] od_index, actual_torque, move_speed, move_ramp_up;
	logic [15:0] move_ramp_down, keypad_alarm, drive_state_word, sp;
	logic [31:0] od_wdata, od_rdata, pos_command, encoder_position;
	logic [31:0] actual_position, actual_speed, move_target, g, d;
	logic [15:0] ri [11] = '{16'h603f, 16'h6040, 16'h6041, 16'h6060,
		16'h6061, 16'h6083, 16'h6084, 16'h60e0, 16'h60e1, 16'h60ff,
		16'h0100};
	int          errors = 0;
	int          n_compared = 0;
	pss_setpoint_status #(.CYCLES_PER_MS(10)) dut (.sys_clk, .rst,
		.od_wr, .od_rd, .od_index, .od_wdata, .od_rdata, .od_ack,
		.pos_command, .encoder_position, .actual_position,
		.actual_speed, .actual_torque, .move_done, .servo_on_pin,
		.run_enable, .new_move, .move_target, .move_speed,
		.move_ramp_up, .move_ramp_down, .pos_reached_do,
		.speed_reached_do, .keypad_alarm, .drive_state_word);
	pss_host host (.sys_clk, .od_wr, .od_rd, .od_index, .od_wdata,
		.od_rdata, .od_ack);
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] goal(input logic [31:0] p,
		input logic [31:0] v, input logic r);
		return r ? p + v : v;
	endfunction : goal
	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		n_compared++;
		if (got !== e) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, e);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [15:0] i, input logic [31:0] v);
		logic [31:0] q;
		logic        a;
		host.acc(1'b1, i, v, q, a);
		chk(32'(a), 32'h1);
	endtask : wr
	task automatic rdc(input logic [15:0] i, input logic [31:0] e);
		logic [31:0] q;
		logic        a;
		host.acc(1'b0, i, 32'h0, q, a);
		chk(q, e);
	endtask : rdc
	task automatic conclude;
		if (errors == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude
	////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		#500000;
		errors++;
		conclude();
	end
	initial begin
		rst = 1'b1;
		move_done = 1'b0;
		servo_on_pin = 1'b1;
		void'($urandom(31));
		pos_command = $urandom & 32'hfffff;
		actual_position = pos_command;
		encoder_position = $urandom;
		actual_torque = $urandom;
		actual_speed = 32'h0;
		sp = $urandom;
		g = 32'h0;
		cyc(8);
		rst = 1'b0;
		foreach (ri[k]) begin
			rdc(ri[k], (k > 4 && k < 9) ? 32'h64 : 32'h0);
		end
		wr(16'h6041, 32'hffff);
		rdc(16'h6041, 32'h0);
		rdc(16'h6063, encoder_position);
		rdc(16'h6077, {16'h0, actual_torque});
		wr(16'h6060, 32'h1);
		rdc(16'h6061, 32'h1);
		wr(16'h6067, 32'h14);
		wr(16'h6068, 32'h2);
		wr(16'h6065, 32'h32);
		wr(16'h6081, {16'h0, sp});
		wr(16'h6040, 32'h0f);
		// immediate: absolute, relative twice, absolute
		for (int k = 0; k < 4; k++) begin
			rel = (k == 1 || k == 2);
			d = $urandom & 32'hffff;
			g = goal(g, d, rel);
			wr(16'h607a, d);
			wr(16'h6040, {25'h0, rel, 6'h3f});
			chk(32'(new_move), 32'h1);
			cyc(1);
			chk(move_target, g);
			chk(32'(drive_state_word[ST_SETPT_ACK]), 32'h1);
			wr(16'h6040, {25'h0, rel, 6'h2f});
			cyc(1);
			chk(32'(drive_state_word[ST_SETPT_ACK]), 32'h0);
		end
		chk(32'(move_speed), 32'(sp));
		chk(32'(move_ramp_up), 32'(RAMP_RST));
		chk(32'(move_ramp_down), 32'(RAMP_RST));
		// deferred while still moving
		wr(16'h607a, $urandom & 32'hffff);
		wr(16'h6040, 32'h1f);
		chk(32'(new_move), 32'h0);
		cyc(1);
		chk(move_target, g);
		chk(32'(drive_state_word[ST_SETPT_ACK]), 32'h0);
		wr(16'h6040, 32'h0f);
		actual_position = pos_command - 32'h15;
		cyc(3);
		chk(32'(pos_reached_do), 32'h0);
		actual_position = pos_command - 32'h14;
		cyc(10);
		chk(32'(pos_reached_do), 32'h0);
		cyc(20);
		chk(32'(pos_reached_do), 32'h1);
		actual_position = pos_command - 32'h15;
		cyc(3);
		chk(32'(pos_reached_do), 32'h0);
		actual_position = pos_command;
		cyc(10);
		chk(32'(pos_reached_do), 32'h0);
		move_done = 1'b1;
		cyc(25);
		chk(32'(drive_state_word[ST_REACHED]), 32'h1);
		d = $urandom & 32'hffff;
		wr(16'h607a, d);
		wr(16'h6040, 32'h1f);
		chk(32'(new_move), 32'h1);
		cyc(1);
		chk(move_target, d);
		chk(32'(drive_state_word[ST_SETPT_ACK]), 32'h1);
		wr(16'h6040, 32'h0f);
		cyc(1);
		chk(32'(drive_state_word[ST_SETPT_ACK]), 32'h0);
		actual_position = pos_command + 32'h32;
		cyc(4);
		chk(32'(drive_state_word[ST_FOLLOW_ERR]), 32'h0);
		actual_position = pos_command + 32'h33;
		cyc(4);
		chk(32'(drive_state_word[ST_FOLLOW_ERR]), 32'h1);
		chk(32'(keypad_alarm), 32'(FOLLOW_ALARM));
		actual_position = pos_command;
		wr(16'h6040, 32'h07);
		cyc(2);
		chk(32'(run_enable), 32'h0);
		wr(16'h6040, 32'h0f);
		cyc(2);
		chk(32'(run_enable), 32'h1);
		// profile velocity operation
		d = $urandom & 32'hffff;
		wr(16'h6060, 32'h3);
		wr(16'h60ff, d);
		wr(16'h606d, 32'ha);
		wr(16'h606e, 32'h1);
		actual_speed = d + 32'ha;
		cyc(25);
		chk(32'(speed_reached_do), 32'h1);
		chk(32'(drive_state_word[ST_REACHED]), 32'h1);
		chk(32'(drive_state_word[ST_SETPT_ACK]), 32'h1);
		servo_on_pin = 1'b0;
		cyc(6);
		chk(32'(speed_reached_do), 32'h0);
		chk(32'(drive_state_word[ST_SETPT_ACK]), 32'h0);
		conclude();
	end
endmodule : pss_setpoint_status_tb
bind pss_setpoint_status pss_setpoint_status_sva chk (.sys_clk, .rst,
	.od_wr, .od_rd, .od_index, .od_rdata, .od_ack, .servo_on_pin,
	.run_enable, .new_move, .move_target, .speed_reached_do,
	.keypad_alarm, .drive_state_word);
